// *** src/ext_temp_pkg.sv ***
package ext_temp_pkg;
	// channel and fixed-point geometry (internal values are signed Q16)
	localparam int CH_COUNT = 2;
	localparam int CH_W     = 1;
	localparam int FX_W     = 40;
	localparam int FX_FRAC  = 16;
	localparam int WIDE_W   = 96;
	localparam int DATA_W   = 32;
	localparam int GAIN_FRAC = 14;

	// command codes of the paged words
	localparam logic [7:0] CMD_OT_FAULT  = 8'h4f;
	localparam logic [7:0] CMD_OT_WARN   = 8'h51;
	localparam logic [7:0] CMD_UT_WARN   = 8'h52;
	localparam logic [7:0] CMD_UT_FAULT  = 8'h53;
	localparam logic [7:0] CMD_HEAT_RISE = 8'hb8;
	localparam logic [7:0] CMD_TAU_INV   = 8'hb9;
	localparam logic [7:0] CMD_THETA     = 8'hba;
	localparam logic [7:0] CMD_GAIN      = 8'hf8;
	localparam logic [7:0] CMD_OFFSET    = 8'hf9;

	// values after reset, and the read data of a refused access
	localparam logic [15:0] RST_OT_FAULT = 16'hea08;
	localparam logic [15:0] RST_OT_WARN  = 16'he3c0;
	localparam logic [15:0] RST_UT_WARN  = 16'h8000;
	localparam logic [15:0] RST_UT_FAULT = 16'hcd80;
	localparam logic [15:0] RST_TAU_INV  = 16'h8000;
	localparam logic [15:0] RST_THETA    = 16'h8000;
	localparam logic [15:0] RST_GAIN     = 16'h4000;
	localparam logic [15:0] RST_OFFSET   = 16'h8000;
	localparam logic [15:0] RD_UNMAPPED  = 16'h0000;

	// fixed-point constants
	localparam logic signed [FX_W-1:0] FX_MAX      = {1'b0, {(FX_W-1){1'b1}}};
	localparam logic signed [FX_W-1:0] FX_MIN      = {1'b1, {(FX_W-1){1'b0}}};
	localparam logic signed [FX_W-1:0] FX_ZERO     = 40'sh00_0000_0000;
	localparam logic signed [FX_W-1:0] FX_UNITY    = 40'sh00_0001_0000;
	localparam logic signed [FX_W-1:0] KELVIN_ZERO = 40'sh00_0111_2666;
	localparam logic signed [FX_W-1:0] HEAT_MAX    = 40'sh00_0032_0000;
	localparam logic signed [FX_W-1:0] CORR_MIN    = 40'sh00_0000_4000;
	localparam logic signed [FX_W-1:0] CORR_MAX    = 40'sh00_0004_0000;
	localparam logic signed [FX_W-1:0] T_REF       = 40'sh00_0019_0000;
	localparam logic signed [23:0]     PPM_RECIP   = 24'sh10c6f8;
	localparam int                     PPM_SHIFT   = 40;
	localparam logic [4:0]             HEAT_RD_EXP = 5'h1c;
	localparam int                     HEAT_RD_SHIFT = 12;

	// decoder slots
	localparam int DEC_OT_FAULT = 0;
	localparam int DEC_OT_WARN  = 1;
	localparam int DEC_UT_WARN  = 2;
	localparam int DEC_UT_FAULT = 3;
	localparam int DEC_OFFSET   = 4;
	localparam int DEC_TAU      = 5;
	localparam int DEC_THETA    = 6;
	localparam int DEC_N        = 7;

	typedef enum logic [1:0] {
		S_IDLE    = 2'b00,
		S_CONVERT = 2'b01,
		S_MODEL   = 2'b10,
		S_FINISH  = 2'b11
	} fsm_t;

	typedef struct packed {
		logic ot_fault;
		logic ot_warn;
		logic ut_warn;
		logic ut_fault;
	} lim_flags_t;

	typedef struct packed {
		logic [CH_W-1:0]          ch;
		logic                     diode_ok;
		logic [DATA_W-1:0]        diode_kelvin;
		logic signed [DATA_W-1:0] die_temp;
		logic signed [DATA_W-1:0] iout;
		logic signed [DATA_W-1:0] current_sense_pos;
		logic signed [DATA_W-1:0] current_sense_neg;
	} meas_t;

	typedef struct packed {
		logic            wr;
		logic            rd;
		logic [CH_W-1:0] page;
		logic [7:0]      cmd;
		logic [15:0]     wdata;
	} reg_req_t;

	typedef struct packed {
		logic        valid;
		logic        err;
		logic [15:0] rdata;
	} reg_rsp_t;

	typedef struct packed {
		logic                   valid;
		logic [CH_W-1:0]        ch;
		logic signed [FX_W-1:0] temp;
		logic signed [FX_W-1:0] inductor_temp;
		logic signed [FX_W-1:0] heat;
		logic signed [FX_W-1:0] corr;
	} result_t;

	// saturate a wide intermediate into the internal format
	function automatic logic signed [FX_W-1:0] sat_fx(input logic signed [WIDE_W-1:0] v);
		if (v > WIDE_W'(FX_MAX))
			return FX_MAX;
		if (v < WIDE_W'(FX_MIN))
			return FX_MIN;
		return v[FX_W-1:0];
	endfunction

	// Q16 product kept in full width before the rescale
	function automatic logic signed [FX_W-1:0] mul_q(input logic signed [FX_W-1:0] a,
			input logic signed [FX_W-1:0] b);
		logic signed [WIDE_W-1:0] p;
		p = WIDE_W'(a) * WIDE_W'(b);
		return sat_fx(p >>> FX_FRAC);
	endfunction
endpackage

// *** src/l11_decode.sv ***
`timescale 1ns/1ps
module l11_decode
	import ext_temp_pkg::*;
(
	// linear word in
	input  wire logic [15:0]          word_in,
	// signed Q16 value out
	output logic signed [FX_W-1:0]    value_out
);
	logic [5:0]               shamt;
	logic signed [WIDE_W-1:0] wide;

	// exponent rebased so the mantissa lands on the Q16 binary point
	always_comb begin
		shamt     = {word_in[15], word_in[15:11]} + 6'(FX_FRAC);
		wide      = WIDE_W'(signed'(word_in[10:0])) <<< shamt;
		value_out = sat_fx(wide);
	end
endmodule

// *** src/ext_temp_calib_self_heat.sv ***
`timescale 1ns/1ps
module ext_temp_calib_self_heat
	import ext_temp_pkg::*;
#(
	parameter int NUM_CH = CH_COUNT
) (
	// clock and reset
	input  wire logic               core_clk_in,
	input  wire logic               srst_in,
	// conversion results from the front end
	input  wire meas_t              meas_in,
	input  wire logic               meas_valid_in,
	output logic                    meas_ready_out,
	// gain temperature coefficient, ppm per degree
	input  wire logic signed [15:0] gain_tc_in,
	// paged command access
	input  wire reg_req_t           reg_req_in,
	output reg_rsp_t                reg_rsp_out,
	// results and limit status
	output result_t                 result_out,
	output lim_flags_t [NUM_CH-1:0] limit_status_out
);
	if (NUM_CH < 1 || NUM_CH > (1 << CH_W)) begin : g_bad_ch
		$error("NUM_CH does not fit the page field");
	end

	typedef struct packed {
		fsm_t                              state;
		logic                              ready;
		logic [CH_W-1:0]                   ch;
		meas_t                             meas;
		logic [NUM_CH-1:0][15:0]           ot_fault;
		logic [NUM_CH-1:0][15:0]           ot_warn;
		logic [NUM_CH-1:0][15:0]           ut_warn;
		logic [NUM_CH-1:0][15:0]           ut_fault;
		logic [NUM_CH-1:0][15:0]           gain;
		logic [NUM_CH-1:0][15:0]           offset;
		logic [NUM_CH-1:0][15:0]           tau_inv;
		logic [NUM_CH-1:0][15:0]           theta;
		logic [NUM_CH-1:0][FX_W-1:0]       heat;
		logic signed [FX_W-1:0]            ts;
		logic signed [FX_W-1:0]            heat_new;
		lim_flags_t [NUM_CH-1:0]           flags;
		reg_rsp_t                          rsp;
		result_t                           res;
	} state_t;

	state_t st;
	state_t next_st;

	// datapath helpers
	logic [15:0]              coef_word [DEC_N];
	logic signed [FX_W-1:0]   coef_fx [DEC_N];
	logic signed [FX_W-1:0]   kelvin_fx;
	logic signed [FX_W-1:0]   gain_fx;
	logic signed [FX_W-1:0]   ts_calc;
	logic signed [FX_W-1:0]   sense_diff;
	logic signed [FX_W-1:0]   power_c;
	logic signed [FX_W-1:0]   target_c;
	logic signed [FX_W-1:0]   heat_old;
	logic signed [FX_W-1:0]   step_c;
	logic signed [FX_W-1:0]   heat_raw;
	logic signed [FX_W-1:0]   heat_calc;
	logic signed [FX_W-1:0]   ti_c;
	logic signed [FX_W-1:0]   dt_c;
	logic signed [FX_W-1:0]   frac_c;
	logic signed [FX_W-1:0]   corr_raw;
	logic signed [FX_W-1:0]   corr_c;
	logic                     coef_off;
	logic                     accept;
	logic [CH_W-1:0]          pg;
	logic [15:0]              rd_word;
	logic [15:0]              heat_word;

	// words of the channel in flight, decoded side by side
	assign coef_word[DEC_OT_FAULT] = st.ot_fault[st.ch];
	assign coef_word[DEC_OT_WARN]  = st.ot_warn[st.ch];
	assign coef_word[DEC_UT_WARN]  = st.ut_warn[st.ch];
	assign coef_word[DEC_UT_FAULT] = st.ut_fault[st.ch];
	assign coef_word[DEC_OFFSET]   = st.offset[st.ch];
	assign coef_word[DEC_TAU]      = st.tau_inv[st.ch];
	assign coef_word[DEC_THETA]    = st.theta[st.ch];

	for (genvar i = 0; i < DEC_N; i++) begin : g_dec
		l11_decode u_dec (
			.word_in   (coef_word[i]),
			.value_out (coef_fx[i])
		);
	end

	// conversion and heat model arithmetic; wide products avoid overflow before saturation
	always_comb begin
		kelvin_fx  = FX_W'(st.meas.diode_kelvin);
		gain_fx    = FX_W'({st.gain[st.ch], 2'b00});
		ts_calc    = sat_fx(WIDE_W'(mul_q(kelvin_fx, gain_fx)) - WIDE_W'(KELVIN_ZERO)
			+ WIDE_W'(coef_fx[DEC_OFFSET]));
		// die temperature replaces the diode, gain and offset unused
		if (!st.meas.diode_ok)
			ts_calc = FX_W'(st.meas.die_temp);
		// power from current and sense difference
		sense_diff = FX_W'(st.meas.current_sense_pos) - FX_W'(st.meas.current_sense_neg);
		power_c    = mul_q(FX_W'(st.meas.iout), sense_diff);
		target_c   = mul_q(coef_fx[DEC_THETA], power_c);
		heat_old   = $signed(st.heat[st.ch]);
		// increment toward steady state scaled by inverse constant
		step_c     = mul_q(sat_fx(WIDE_W'(target_c) - WIDE_W'(heat_old)), coef_fx[DEC_TAU]);
		coef_off   = (coef_fx[DEC_THETA] <= FX_ZERO) || (coef_fx[DEC_TAU] <= FX_ZERO);
		// nonpositive coefficients switch the model off
		if (coef_off)
			heat_raw = FX_ZERO;
		// a unit inverse constant jumps straight to steady state
		else if (coef_fx[DEC_TAU] >= FX_UNITY)
			heat_raw = target_c;
		else
			heat_raw = sat_fx(WIDE_W'(heat_old) + WIDE_W'(step_c));
		// keep the rise inside 0..50 degrees
		if (heat_raw < FX_ZERO)
			heat_calc = FX_ZERO;
		else if (heat_raw > HEAT_MAX)
			heat_calc = HEAT_MAX;
		else
			heat_calc = heat_raw;
		// inductor temperature drives the gain correction
		ti_c     = sat_fx(WIDE_W'(st.ts) + WIDE_W'(st.heat_new));
		dt_c     = sat_fx(WIDE_W'(ti_c) - WIDE_W'(T_REF));
		frac_c   = sat_fx((WIDE_W'(gain_tc_in) * WIDE_W'(dt_c) * WIDE_W'(PPM_RECIP))
			>>> PPM_SHIFT);
		corr_raw = sat_fx(WIDE_W'(FX_UNITY) + WIDE_W'(frac_c));
		// correction held between quarter and four
		if (corr_raw < CORR_MIN)
			corr_c = CORR_MIN;
		else if (corr_raw > CORR_MAX)
			corr_c = CORR_MAX;
		else
			corr_c = corr_raw;
	end

	assign pg        = reg_req_in.page;
	// rise reported with a fixed exponent of -4, 1/16 degree steps
	assign heat_word = {HEAT_RD_EXP, st.heat[pg][HEAT_RD_SHIFT +: 11]};
	assign accept    = meas_valid_in && st.ready && (int'(meas_in.ch) < NUM_CH);

	// next state: register access and the conversion sequence
	always_comb begin
		next_st           = st;
		next_st.rsp.valid = 1'b0;
		next_st.rsp.err   = 1'b0;
		next_st.res.valid = 1'b0;
		rd_word           = RD_UNMAPPED;
		if (reg_req_in.wr || reg_req_in.rd) begin
			next_st.rsp.valid = 1'b1;
			if (int'(pg) >= NUM_CH) begin
				next_st.rsp.err = 1'b1;
			end else begin
				// limit and coefficient words writable per page
				unique case (reg_req_in.cmd)
					CMD_OT_FAULT: begin
						rd_word = st.ot_fault[pg];
						if (reg_req_in.wr)
							next_st.ot_fault[pg] = reg_req_in.wdata;
					end
					CMD_OT_WARN: begin
						rd_word = st.ot_warn[pg];
						if (reg_req_in.wr)
							next_st.ot_warn[pg] = reg_req_in.wdata;
					end
					CMD_UT_WARN: begin
						rd_word = st.ut_warn[pg];
						if (reg_req_in.wr)
							next_st.ut_warn[pg] = reg_req_in.wdata;
					end
					CMD_UT_FAULT: begin
						rd_word = st.ut_fault[pg];
						if (reg_req_in.wr)
							next_st.ut_fault[pg] = reg_req_in.wdata;
					end
					CMD_TAU_INV: begin
						rd_word = st.tau_inv[pg];
						if (reg_req_in.wr)
							next_st.tau_inv[pg] = reg_req_in.wdata;
					end
					CMD_THETA: begin
						rd_word = st.theta[pg];
						if (reg_req_in.wr)
							next_st.theta[pg] = reg_req_in.wdata;
					end
					CMD_GAIN: begin
						rd_word = st.gain[pg];
						if (reg_req_in.wr)
							next_st.gain[pg] = reg_req_in.wdata;
					end
					CMD_OFFSET: begin
						rd_word = st.offset[pg];
						if (reg_req_in.wr)
							next_st.offset[pg] = reg_req_in.wdata;
					end
					// the rise is read only, a write is refused
					CMD_HEAT_RISE: begin
						rd_word = heat_word;
						if (reg_req_in.wr)
							next_st.rsp.err = 1'b1;
					end
					default: begin
						next_st.rsp.err = 1'b1;
					end
				endcase
			end
			next_st.rsp.rdata = (reg_req_in.rd && !next_st.rsp.err) ? rd_word : RD_UNMAPPED;
		end

		// one model step per accepted external conversion
		unique case (st.state)
			S_IDLE: begin
				if (accept) begin
					next_st.meas  = meas_in;
					next_st.ch    = meas_in.ch;
					next_st.ready = 1'b0;
					next_st.state = S_CONVERT;
				end
			end
			S_CONVERT: begin
				// model input is the same substituted reading
				next_st.ts    = ts_calc;
				next_st.state = S_MODEL;
			end
			S_MODEL: begin
				next_st.heat[st.ch] = heat_calc;
				next_st.heat_new    = heat_calc;
				next_st.state       = S_FINISH;
			end
			S_FINISH: begin
				// four limits checked against the fresh reading
				next_st.flags[st.ch] = {st.ts > coef_fx[DEC_OT_FAULT],
					st.ts > coef_fx[DEC_OT_WARN],
					st.ts < coef_fx[DEC_UT_WARN],
					st.ts < coef_fx[DEC_UT_FAULT]};
				next_st.res.valid         = 1'b1;
				next_st.res.ch            = st.ch;
				next_st.res.temp          = st.ts;
				next_st.res.inductor_temp = ti_c;
				next_st.res.heat          = st.heat_new;
				next_st.res.corr          = corr_c;
				next_st.ready             = 1'b1;
				next_st.state             = S_IDLE;
			end
		endcase
	end

	// state register; a write in the same cycle as reset is lost
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			// self heat and outputs start cleared, except meas_ready_out which starts high
			st          <= '0;
			st.state    <= S_IDLE;
			st.ready    <= 1'b1;
			st.ot_fault <= {NUM_CH{RST_OT_FAULT}};
			st.ot_warn  <= {NUM_CH{RST_OT_WARN}};
			st.ut_warn  <= {NUM_CH{RST_UT_WARN}};
			st.ut_fault <= {NUM_CH{RST_UT_FAULT}};
			st.gain     <= {NUM_CH{RST_GAIN}};
			st.offset   <= {NUM_CH{RST_OFFSET}};
			st.tau_inv  <= {NUM_CH{RST_TAU_INV}};
			st.theta    <= {NUM_CH{RST_THETA}};
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign meas_ready_out   = st.ready;
	assign reg_rsp_out      = st.rsp;
	assign result_out       = st.res;
	assign limit_status_out = st.flags;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (srst_in);

	a_result_latency: assert property (accept |-> ##4 result_out.valid)
		else $error("result not produced four cycles after accept");
	a_busy_refuse: assert property (accept |=> !meas_ready_out [*3] ##1 meas_ready_out)
		else $error("ready not held low during a conversion");
	a_heat_range: assert property (result_out.valid |->
		(result_out.heat >= FX_ZERO) && (result_out.heat <= HEAT_MAX))
		else $error("self heat outside zero to fifty");
	a_coef_zero: assert property ((st.state == S_MODEL) && coef_off |=>
		(st.heat_new == FX_ZERO) ##2 (result_out.heat == FX_ZERO))
		else $error("nonpositive coefficient did not zero self heat");
	a_direct_set: assert property ((st.state == S_MODEL) && !coef_off
		&& (coef_fx[DEC_TAU] >= FX_UNITY) && (target_c >= FX_ZERO) && (target_c <= HEAT_MAX)
		|=> st.heat_new == $past(target_c))
		else $error("unit inverse constant did not set steady state");
	a_die_subst: assert property ((st.state == S_CONVERT) && !st.meas.diode_ok |=>
		##2 (result_out.temp == FX_W'($past(st.meas.die_temp, 3))))
		else $error("die temperature not substituted");
	a_ot_fault_flag: assert property (result_out.valid |->
		limit_status_out[result_out.ch].ot_fault
		== (result_out.temp > $past(coef_fx[DEC_OT_FAULT])))
		else $error("overtemperature fault flag wrong");
	a_ut_fault_flag: assert property (result_out.valid |->
		limit_status_out[result_out.ch].ut_fault
		== (result_out.temp < $past(coef_fx[DEC_UT_FAULT])))
		else $error("undertemperature fault flag wrong");
	a_corr_range: assert property (result_out.valid |->
		(result_out.corr >= CORR_MIN) && (result_out.corr <= CORR_MAX))
		else $error("correction factor outside quarter to four");
	a_gain_default: assert property (disable iff (1'b0)
		$past(srst_in) && !srst_in |-> st.gain[0] == RST_GAIN)
		else $error("gain not unity after reset");
	a_heat_init: assert property (disable iff (1'b0)
		$past(srst_in) && !srst_in |-> st.heat == '0 && st.ot_fault[0] == RST_OT_FAULT)
		else $error("self heat or limit not initialised");

	c_die_used: cover property ((st.state == S_CONVERT) && !st.meas.diode_ok);
	c_ot_fault: cover property (result_out.valid && limit_status_out[result_out.ch].ot_fault);
	c_direct: cover property ((st.state == S_MODEL) && !coef_off && (coef_fx[DEC_TAU] >= FX_UNITY));
	c_heat_max: cover property (result_out.valid && (result_out.heat == HEAT_MAX));
endmodule

// *** sim/diode_frontend_model.sv ***
`timescale 1ns/1ps
module diode_frontend_model
	import ext_temp_pkg::*;
(
	// clock
	input  wire logic       core_clk_in,
	// stimulus from the bench
	input  wire meas_t      req_in,
	input  wire logic       go_in,
	input  wire logic [3:0] gap_in,
	// conversion port of the block
	output meas_t           meas_out,
	output logic            meas_valid_out,
	input  wire logic       meas_ready_in
);
	// one conversion per go, optionally late, held until the block takes it
	initial begin
		meas_valid_out = 1'b0;
		meas_out = '0;
		forever begin
			@(posedge core_clk_in);
			if (go_in) begin
				repeat (gap_in) @(posedge core_clk_in);
				#1;
				meas_out = req_in;
				meas_valid_out = 1'b1;
				do @(posedge core_clk_in); while (!meas_ready_in);
				#1;
				meas_valid_out = 1'b0;
				// released data never repeats the last word, so a late sample shows
				meas_out = ~meas_out;
			end
		end
	end
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench
	import ext_temp_pkg::*;
;
	logic                    clk;
	logic                    srst;
	meas_t                   req;
	logic                    go;
	logic [3:0]              gap;
	meas_t                   meas;
	logic                    meas_valid;
	logic                    meas_ready;
	logic signed [15:0]      gain_tc;
	reg_req_t                reg_req;
	reg_rsp_t                reg_rsp;
	result_t                 result;
	lim_flags_t [CH_COUNT-1:0] flags;
	int                      num_errors = 0;
	int                      compares = 0;
	int                      cycles = 0;
	logic [7:0]  cmds [8] = '{CMD_OT_FAULT, CMD_OT_WARN, CMD_UT_WARN, CMD_UT_FAULT,
		CMD_TAU_INV, CMD_THETA, CMD_GAIN, CMD_OFFSET};
	logic [15:0] rsts [8] = '{RST_OT_FAULT, RST_OT_WARN, RST_UT_WARN, RST_UT_FAULT,
		RST_TAU_INV, RST_THETA, RST_GAIN, RST_OFFSET};
	localparam logic [31:0] K25 = 32'h012a_2666;
	localparam logic [39:0] C1  = 40'h00_0001_0000;

	ext_temp_calib_self_heat #(.NUM_CH(CH_COUNT)) i_dut (
		.core_clk_in      (clk),
		.srst_in          (srst),
		.meas_in          (meas),
		.meas_valid_in    (meas_valid),
		.meas_ready_out   (meas_ready),
		.gain_tc_in       (gain_tc),
		.reg_req_in       (reg_req),
		.reg_rsp_out      (reg_rsp),
		.result_out       (result),
		.limit_status_out (flags)
	);

	diode_frontend_model i_front (
		.core_clk_in    (clk),
		.req_in         (req),
		.go_in          (go),
		.gap_in         (gap),
		.meas_out       (meas),
		.meas_valid_out (meas_valid),
		.meas_ready_in  (meas_ready)
	);

	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			complete_run();
		end
	end

	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one word access; the answer is registered on the taking edge and checked just after it
	task automatic reg_acc(input logic wr, input logic [0:0] pg, input logic [7:0] cmd,
			input logic [15:0] wd, input logic [15:0] exp, input logic exp_err);
		@(posedge clk);
		#1;
		reg_req = '{wr: wr, rd: !wr, page: pg, cmd: cmd, wdata: wd};
		@(posedge clk);
		#1;
		reg_req = '0;
		chk("response valid", 40'h1, 40'(reg_rsp.valid));
		chk("response error", 40'(exp_err), 40'(reg_rsp.err));
		if (!wr)
			chk("read data", 40'(exp), 40'(reg_rsp.rdata));
	endtask

	// one conversion through the front-end model, sense difference fixed at 1.0 V
	task automatic run_meas(input logic [0:0] ch, input logic ok, input logic [31:0] kel,
			input logic [31:0] die, input logic [31:0] io, input logic [3:0] gp);
		int n;
		@(posedge clk);
		#1;
		req = '{ch: ch, diode_ok: ok, diode_kelvin: kel, die_temp: die, iout: io,
			current_sense_pos: 32'h0001_8000, current_sense_neg: 32'h0000_8000};
		gap = gp;
		go = 1'b1;
		@(posedge clk);
		#1;
		go = 1'b0;
		n = 0;
		while (result.valid !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("result valid", 40'h1, 40'(result.valid));
		chk("result channel", 40'(ch), 40'(result.ch));
	endtask

	task automatic exp_res(input logic [39:0] t, input logic [39:0] h, input logic [39:0] c,
			input lim_flags_t f);
		chk("temperature", t, result.temp);
		chk("self heat", h, result.heat);
		chk("inductor temperature", t + h, result.inductor_temp);
		chk("correction", c, result.corr);
		chk("limit flags", 40'(f), 40'(flags[result.ch]));
	endtask

	// main sequence
	initial begin
		srst = 1'b1;
		go = 1'b0;
		gap = 4'h0;
		req = '0;
		reg_req = '0;
		gain_tc = 16'sh0000;
		repeat (5) @(posedge clk);
		#1;
		srst = 1'b0;
		// register defaults on both pages
		for (int p = 0; p < CH_COUNT; p++)
			for (int i = 0; i < 8; i++)
				reg_acc(1'b0, 1'(p), cmds[i], 16'h0000, rsts[i], 1'b0);
		reg_acc(1'b0, 1'b0, CMD_HEAT_RISE, 16'h0000, 16'he000, 1'b0);
		reg_acc(1'b1, 1'b0, CMD_HEAT_RISE, 16'h1234, 16'h0000, 1'b1); // read only
		reg_acc(1'b0, 1'b0, CMD_HEAT_RISE, 16'h0000, 16'he000, 1'b0); // unchanged
		reg_acc(1'b0, 1'b0, 8'h00, 16'h0000, 16'h0000, 1'b1); // unmapped refused
		$display("register test done");
		// nominal diode, default coefficients keep heat at zero despite current
		run_meas(1'b0, 1'b1, K25, 32'h0, 32'h0002_0000, 4'h0);
		exp_res(40'h00_0019_0000, 40'h0, C1, 4'b0000);
		// offsets walk the reading across the limit edges
		reg_acc(1'b1, 1'b0, CMD_OFFSET, 16'h07e2, 16'h0000, 1'b0);
		run_meas(1'b0, 1'b1, K25, 32'h0, 32'h0, 4'h2);
		exp_res(40'hff_fffb_0000, 40'h0, C1, 4'b0010); // strict fault edge
		reg_acc(1'b1, 1'b0, CMD_OFFSET, 16'h07e1, 16'h0000, 1'b0);
		run_meas(1'b0, 1'b1, K25, 32'h0, 32'h0, 4'h0);
		exp_res(40'hff_fffa_0000, 40'h0, C1, 4'b0011); // under fault
		reg_acc(1'b1, 1'b0, CMD_OFFSET, 16'h0028, 16'h0000, 1'b0);
		run_meas(1'b0, 1'b1, K25, 32'h0, 32'h0, 4'h0);
		exp_res(40'h00_0041_0000, 40'h0, C1, 4'b0100); // fault limit edge
		reg_acc(1'b1, 1'b0, CMD_OFFSET, 16'h0000, 16'h0000, 1'b0);
		reg_acc(1'b1, 1'b0, CMD_GAIN, 16'h8000, 16'h0000, 1'b0);
		reg_acc(1'b0, 1'b0, CMD_GAIN, 16'h0000, 16'h8000, 1'b0); // readback
		reg_acc(1'b0, 1'b1, CMD_GAIN, 16'h0000, RST_GAIN, 1'b0); // other page
		run_meas(1'b0, 1'b1, K25, 32'h0, 32'h0, 4'h0);
		exp_res(40'h00_0143_2666, 40'h0, C1, 4'b1100); // gain two
		run_meas(1'b0, 1'b0, K25, 32'h0046_0000, 32'h0, 4'h0);
		exp_res(40'h00_0046_0000, 40'h0, C1, 4'b1100); // die fallback
		$display("temperature test done");
		// self heat on page one: two half steps, then direct steady state
		reg_acc(1'b1, 1'b1, CMD_THETA, 16'h0002, 16'h0000, 1'b0);
		reg_acc(1'b1, 1'b1, CMD_TAU_INV, 16'hf801, 16'h0000, 1'b0);
		run_meas(1'b1, 1'b1, K25, 32'h0, 32'h0002_0000, 4'h0);
		exp_res(40'h00_0019_0000, 40'h00_0002_0000, C1, 4'b0000);
		run_meas(1'b1, 1'b1, K25, 32'h0, 32'h0002_0000, 4'h3);
		exp_res(40'h00_0019_0000, 40'h00_0003_0000, C1, 4'b0000);
		reg_acc(1'b0, 1'b1, CMD_HEAT_RISE, 16'h0000, 16'he030, 1'b0); // paged
		reg_acc(1'b0, 1'b0, CMD_HEAT_RISE, 16'h0000, 16'he000, 1'b0); // paged
		reg_acc(1'b1, 1'b1, CMD_TAU_INV, 16'h0001, 16'h0000, 1'b0);
		run_meas(1'b1, 1'b1, K25, 32'h0, 32'h0002_0000, 4'h0);
		exp_res(40'h00_0019_0000, 40'h00_0004_0000, C1, 4'b0000);
		run_meas(1'b1, 1'b1, K25, 32'h0, 32'h0028_0000, 4'h0);
		exp_res(40'h00_0019_0000, 40'h00_0032_0000, C1, 4'b0000); // upper clamp
		reg_acc(1'b0, 1'b1, CMD_HEAT_RISE, 16'h0000, 16'he320, 1'b0);
		run_meas(1'b1, 1'b1, K25, 32'h0, 32'hffff_0000, 4'h0);
		exp_res(40'h00_0019_0000, 40'h0, C1, 4'b0000); // lower clamp
		reg_acc(1'b1, 1'b1, CMD_THETA, 16'h07ff, 16'h0000, 1'b0);
		run_meas(1'b1, 1'b1, K25, 32'h0, 32'h0002_0000, 4'h0);
		exp_res(40'h00_0019_0000, 40'h0, C1, 4'b0000); // negative theta
		$display("self heat test done");
		// die input drives the model and the correction reaches both limits
		reg_acc(1'b1, 1'b1, CMD_THETA, 16'h0002, 16'h0000, 1'b0);
		gain_tc = 16'sh7fff;
		run_meas(1'b1, 1'b0, K25, 32'h0096_0000, 32'h0028_0000, 4'h0);
		exp_res(40'h00_0096_0000, 40'h00_0032_0000, 40'h00_0004_0000, 4'b1100);
		gain_tc = 16'sh8000;
		run_meas(1'b1, 1'b0, K25, 32'h0096_0000, 32'h0028_0000, 4'h0);
		exp_res(40'h00_0096_0000, 40'h00_0032_0000, 40'h00_0000_4000, 4'b1100);
		// 10000 ppm over 25 degrees above reference gives a factor of 1.25
		gain_tc = 16'sh2710;
		run_meas(1'b0, 1'b0, K25, 32'h0032_0000, 32'h0, 4'h0);
		exp_res(40'h00_0032_0000, 40'h0, 40'h00_0001_4000, 4'b0000); // unclamped factor
		$display("correction test done");
		complete_run();
	end
endmodule
